// *** hw/fpl_top.sv ***
// fault supervision, protection latch and limit configuration of a buck controller
//
// What this block does
// - droop coefficient 0/25/50/100 percent, reset 0%
// - sample external current limit at power on
// - internal 5-bit current limit field
// - select bit picks sampled or internal limit
// - stage temperature high is a fault
// - stage fault latches, or hiccups if configured
// - masked stage temperature fault only sets its status bit
// - per-phase limiter active unless bypass runs
// - output undervoltage latches shutdown
// - undervoltage latch held until enable toggles
// - bypass floor hit suspends limiter 2 ms
// - bypass floor programmable, disabled at reset
// - total current fault latches, pwm mid-state
// - regulation held off until supply lockout clears
// - overvoltage drops good, driver, pwm low, latches
// - disabled overvoltage still clamps at 2 V
// - line undervoltage latches shutdown
// - line latch restarts on toggle and line ok
// - die over temperature reported
// - die fault latches or hiccups as configured
`timescale 1ns/1ps
module fpl_top
#(
  parameter int BYPASS_CYCLES = fpl_pkg::FPL_BYPASS_CYCLES,
  parameter int HICCUP_CYCLES = fpl_pkg::FPL_HICCUP_CYCLES
)
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // register port behind the serial interface
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // comparator and monitor inputs
  input  wire logic       supply_ok_i,
  input  wire logic       enable_i,
  input  wire logic       uv_cmp_i,
  input  wire logic       ov_cmp_i,
  input  wire logic       ov_clamp_cmp_i,
  input  wire logic       total_current_low_i,
  input  wire logic       line_uv_i,
  input  wire logic       line_ok_i,
  input  wire logic       stage_temp_high_i,
  input  wire logic       die_hot_i,
  input  wire logic       current_limiting_i,
  input  wire logic       bypass_floor_hit_i,
  input  wire logic [7:0] phase_current_limit_adc_i,
  // control outputs
  output logic            regulation_enable_o,
  output logic            soft_start_enable_o,
  output logic            power_good_out_o,
  output logic            driver_enable_out_o,
  output fpl_pkg::fpl_pwm_e pwm_mode_o,
  output logic            limiter_active_o,
  output logic      [1:0] droop_sel_o,
  output logic      [7:0] active_limit_o,
  output logic            limit_internal_o,
  output logic      [4:0] bypass_floor_o,
  output logic            die_fault_o
);
  import fpl_pkg::*;

  fpl_state_e  state;
  fpl_state_e  next_state;
  logic [7:0]  fault_mask;
  logic [7:0]  current_limit_sampled;
  logic [4:0]  current_limit_internal;
  logic [1:0]  droop_coefficient_config;
  logic [7:0]  second_function_latch_a;
  logic [7:0]  second_function_latch_b;
  logic [7:0]  stage_resp;
  logic [7:0]  die_resp;
  logic [7:0]  floor_cfg;
  logic [7:0]  ov_cfg;
  logic [5:0]  fault_status;
  logic        supply_seen;
  logic        enable_seen_low;
  logic        line_latched;
  logic        mid_latched;
  logic        uv_ev;
  logic        ov_ev;
  logic        total_ev;
  logic        line_ev;
  logic        stage_ev;
  logic        die_ev;
  logic        latch_now;
  logic        hiccup_now;
  logic        release_ok;
  logic        bypass_start;
  logic        bypass_busy;
  logic        hiccup_start;
  logic        hiccup_done;

  // fault qualification
  assign uv_ev    = uv_cmp_i;
  assign ov_ev    = ov_cfg[FPL_OV_DIS_BIT] ? ov_clamp_cmp_i : ov_cmp_i;
  assign total_ev = total_current_low_i & ~fault_mask[FPL_MASK_TOTAL_BIT];
  assign line_ev  = line_uv_i & ~fault_mask[FPL_MASK_LINE_BIT];
  assign stage_ev = stage_temp_high_i & ~fault_mask[FPL_MASK_STAGE_BIT];
  assign die_ev   = die_hot_i & ~fault_mask[FPL_MASK_DIE_BIT];

  assign latch_now = uv_ev | ov_ev | total_ev | line_ev
                   | (stage_ev & ~stage_resp[FPL_HICCUP_BIT])
                   | (die_ev & ~die_resp[FPL_HICCUP_BIT]);
  assign hiccup_now = ~latch_now
                    & ((stage_ev & stage_resp[FPL_HICCUP_BIT])
                    | (die_ev & die_resp[FPL_HICCUP_BIT]));

  // leaving a latch needs enable low then high, and line ok after a line fault
  assign release_ok = enable_seen_low & enable_i & (~line_latched | line_ok_i);

  assign hiccup_start = (state == FPL_RUN) && (next_state == FPL_HICCUP);
  assign bypass_start = (state == FPL_RUN) && floor_cfg[FPL_FLOOR_EN_BIT]
                      && current_limiting_i && bypass_floor_hit_i && !bypass_busy;

  always_comb
  begin
    next_state = state;
    unique case (state)
      FPL_LOCKOUT:
      begin
        if (supply_ok_i && enable_i)
          next_state = FPL_RUN;
      end
      FPL_RUN:
      begin
        if (!supply_ok_i || !enable_i)
          next_state = FPL_LOCKOUT;
        else if (latch_now)
          next_state = FPL_LATCH;
        else if (hiccup_now)
          next_state = FPL_HICCUP;
      end
      FPL_HICCUP:
      begin
        if (hiccup_done)
          next_state = FPL_LOCKOUT;
      end
      FPL_LATCH:
      begin
        if (release_ok)
          next_state = FPL_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= FPL_LOCKOUT;
    else
      state <= next_state;
  end

  // latch bookkeeping
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enable_seen_low <= 1'b0;
      line_latched    <= 1'b0;
      mid_latched     <= 1'b0;
    end
    else if (state == FPL_RUN && next_state == FPL_LATCH)
    begin
      enable_seen_low <= 1'b0;
      line_latched    <= line_ev;
      mid_latched     <= total_ev;
    end
    else if (state == FPL_LATCH)
    begin
      enable_seen_low <= enable_seen_low | ~enable_i;
      if (next_state != FPL_LATCH)
      begin
        line_latched <= 1'b0;
        mid_latched  <= 1'b0;
      end
    end
  end

  // sticky fault report; a new event wins over the restart clear
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fault_status <= FPL_RST_STATUS;
    else
    begin
      if (state == FPL_LATCH && next_state != FPL_LATCH)
        fault_status <= FPL_RST_STATUS;
      if (uv_cmp_i)
        fault_status[FPL_ST_UV] <= 1'b1;
      if (ov_ev)
        fault_status[FPL_ST_OV] <= 1'b1;
      if (total_current_low_i)
        fault_status[FPL_ST_TOTAL] <= 1'b1;
      if (line_uv_i)
        fault_status[FPL_ST_LINE] <= 1'b1;
      if (stage_temp_high_i)
        fault_status[FPL_ST_STAGE] <= 1'b1;
      if (die_hot_i)
        fault_status[FPL_ST_DIE] <= 1'b1;
    end
  end

  // external limit captured each time the supply comes up
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      supply_seen           <= 1'b0;
      current_limit_sampled <= FPL_RST_BYTE;
    end
    else
    begin
      supply_seen <= supply_ok_i;
      if (supply_ok_i && !supply_seen)
        current_limit_sampled <= phase_current_limit_adc_i;
    end
  end

  // register writes
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fault_mask               <= FPL_RST_BYTE;
      current_limit_internal   <= FPL_RST_LIMIT_INT;
      droop_coefficient_config <= FPL_RST_DROOP;
      second_function_latch_a  <= FPL_RST_BYTE;
      second_function_latch_b  <= FPL_RST_BYTE;
      stage_resp               <= FPL_RST_BYTE;
      die_resp                 <= FPL_RST_BYTE;
      floor_cfg                <= FPL_RST_BYTE;
      ov_cfg                   <= FPL_RST_BYTE;
    end
    else if (reg_write_i)
    begin
      unique case (reg_addr_i)
        FPL_OFF_FAULT_MASK: fault_mask               <= reg_wdata_i;
        FPL_OFF_LIMIT_INT:  current_limit_internal   <= reg_wdata_i[4:0];
        FPL_OFF_DROOP:      droop_coefficient_config <= reg_wdata_i[1:0];
        FPL_OFF_LATCH_A:    second_function_latch_a  <= reg_wdata_i;
        FPL_OFF_LATCH_B:    second_function_latch_b  <= reg_wdata_i;
        FPL_OFF_STAGE_RESP: stage_resp               <= reg_wdata_i;
        FPL_OFF_DIE_RESP:   die_resp                 <= reg_wdata_i;
        FPL_OFF_FLOOR:      floor_cfg                <= reg_wdata_i;
        FPL_OFF_OV_CFG:     ov_cfg                   <= reg_wdata_i;
        default:            ;
      endcase
    end
  end

  // register reads, unmapped offsets answer zero
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= FPL_RST_BYTE;
    else if (reg_read_i)
    begin
      unique case (reg_addr_i)
        FPL_OFF_FAULT_MASK:   reg_rdata_o <= fault_mask;
        FPL_OFF_FAULT_STATUS: reg_rdata_o <= {2'h0, fault_status};
        FPL_OFF_LIMIT_SAMP:   reg_rdata_o <= current_limit_sampled;
        FPL_OFF_LIMIT_INT:    reg_rdata_o <= {3'h0, current_limit_internal};
        FPL_OFF_DROOP:        reg_rdata_o <= {6'h00, droop_coefficient_config};
        FPL_OFF_LATCH_A:      reg_rdata_o <= second_function_latch_a;
        FPL_OFF_LATCH_B:      reg_rdata_o <= second_function_latch_b;
        FPL_OFF_STAGE_RESP:   reg_rdata_o <= stage_resp;
        FPL_OFF_DIE_RESP:     reg_rdata_o <= die_resp;
        FPL_OFF_FLOOR:        reg_rdata_o <= floor_cfg;
        FPL_OFF_OV_CFG:       reg_rdata_o <= ov_cfg;
        default:              reg_rdata_o <= FPL_RST_BYTE;
      endcase
    end
  end

  fpl_timer #(
    .CYCLES (BYPASS_CYCLES)
  ) u_bypass_timer (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .start_i   (bypass_start),
    .busy_o    (bypass_busy),
    .done_o    ()
  );

  fpl_timer #(
    .CYCLES (HICCUP_CYCLES)
  ) u_hiccup_timer (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .start_i   (hiccup_start),
    .busy_o    (),
    .done_o    (hiccup_done)
  );

  // registered outputs
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      regulation_enable_o <= 1'b0;
      soft_start_enable_o <= 1'b0;
      power_good_out_o    <= 1'b0;
      driver_enable_out_o <= 1'b0;
      pwm_mode_o          <= FPL_PWM_LOW;
      limiter_active_o    <= 1'b1;
      die_fault_o         <= 1'b0;
      active_limit_o      <= FPL_RST_BYTE;
    end
    else
    begin
      regulation_enable_o <= supply_ok_i;
      soft_start_enable_o <= (next_state == FPL_RUN);
      power_good_out_o    <= (next_state == FPL_RUN);
      driver_enable_out_o <= (next_state == FPL_RUN);
      if (next_state == FPL_RUN)
        pwm_mode_o <= FPL_PWM_ACTIVE;
      else if (next_state == FPL_LATCH && (mid_latched || (state == FPL_RUN && total_ev)))
        pwm_mode_o <= FPL_PWM_MID;
      else
        pwm_mode_o <= FPL_PWM_LOW;
      limiter_active_o    <= !(bypass_busy || bypass_start);
      die_fault_o         <= fault_status[FPL_ST_DIE] | die_hot_i;
      active_limit_o      <= second_function_latch_a[FPL_LIMIT_SRC_BIT]
                             ? {3'h0, current_limit_internal} : current_limit_sampled;
    end
  end

  assign droop_sel_o      = droop_coefficient_config;
  assign limit_internal_o = second_function_latch_a[FPL_LIMIT_SRC_BIT];
  assign bypass_floor_o   = floor_cfg[4:0];

  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  property p_uv_latch;
    (state == FPL_RUN && supply_ok_i && enable_i && uv_cmp_i) |=> (state == FPL_LATCH);
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("undervoltage did not latch");

  property p_latch_hold;
    (state == FPL_LATCH && !enable_seen_low) |=> (state == FPL_LATCH) && !power_good_out_o;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch left without toggle");

  property p_ov_off;
    (state == FPL_RUN && supply_ok_i && enable_i && ov_ev && !total_ev)
      |=> (!power_good_out_o && !driver_enable_out_o && pwm_mode_o == FPL_PWM_LOW);
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage outputs wrong");

  property p_total_mid;
    (state == FPL_RUN && supply_ok_i && enable_i && total_ev)
      |=> (pwm_mode_o == FPL_PWM_MID) ##1 (state == FPL_LATCH);
  endproperty
  a_total_mid: assert property (p_total_mid) else $error("total fault not mid-state");

  property p_lockout;
    !supply_ok_i |=> (!regulation_enable_o && !soft_start_enable_o);
  endproperty
  a_lockout: assert property (p_lockout) else $error("regulation active in lockout");

  property p_line_hold;
    (state == FPL_LATCH && line_latched && !line_ok_i) |=> (state == FPL_LATCH);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line latch released early");

  property p_bypass;
    bypass_start |=> !limiter_active_o [*3];
  endproperty
  a_bypass: assert property (p_bypass) else $error("limiter not suspended");

  property p_droop_write;
    (reg_write_i && reg_addr_i == FPL_OFF_DROOP) |=> (droop_sel_o == $past(reg_wdata_i[1:0]));
  endproperty
  a_droop_write: assert property (p_droop_write) else $error("droop select not updated");

  property p_sample;
    (supply_ok_i && !supply_seen) |=> (current_limit_sampled == $past(phase_current_limit_adc_i));
  endproperty
  a_sample: assert property (p_sample) else $error("limit not sampled at power on");

  property p_hiccup;
    (state == FPL_RUN && supply_ok_i && enable_i && hiccup_now) |=> (state == FPL_HICCUP);
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("hiccup not entered");

  property p_mask_stage;
    (state == FPL_RUN && fault_mask[FPL_MASK_STAGE_BIT] && !uv_ev && !ov_ev && !total_ev
      && !line_ev && !die_ev && supply_ok_i && enable_i) |=> (state == FPL_RUN);
  endproperty
  a_mask_stage: assert property (p_mask_stage) else $error("masked stage fault acted");

endmodule

// *** common/fpl_pkg.sv ***
// constants, register map and state types of the fault protection latch
package fpl_pkg;

  // register offsets
  localparam logic [7:0] FPL_OFF_FAULT_MASK   = 8'h22;
  localparam logic [7:0] FPL_OFF_FAULT_STATUS = 8'h23;
  localparam logic [7:0] FPL_OFF_LIMIT_SAMP   = 8'h2d;
  localparam logic [7:0] FPL_OFF_LIMIT_INT    = 8'h2e;
  localparam logic [7:0] FPL_OFF_DROOP        = 8'h39;
  localparam logic [7:0] FPL_OFF_LATCH_A      = 8'h46;
  localparam logic [7:0] FPL_OFF_LATCH_B      = 8'h47;
  localparam logic [7:0] FPL_OFF_STAGE_RESP   = 8'h4a;
  localparam logic [7:0] FPL_OFF_DIE_RESP     = 8'h4b;
  localparam logic [7:0] FPL_OFF_FLOOR        = 8'h4e;
  localparam logic [7:0] FPL_OFF_OV_CFG       = 8'h4f;

  // reset values
  localparam logic [7:0] FPL_RST_BYTE      = 8'h00;
  localparam logic [4:0] FPL_RST_LIMIT_INT = 5'h00;
  localparam logic [1:0] FPL_RST_DROOP     = 2'h3;
  localparam logic [5:0] FPL_RST_STATUS    = 6'h00;

  // field positions
  localparam int FPL_MASK_LINE_BIT  = 6;
  localparam int FPL_MASK_STAGE_BIT = 5;
  localparam int FPL_MASK_DIE_BIT   = 4;
  localparam int FPL_MASK_TOTAL_BIT = 3;
  localparam int FPL_LIMIT_SRC_BIT  = 0;
  localparam int FPL_HICCUP_BIT     = 0;
  localparam int FPL_FLOOR_EN_BIT   = 7;
  localparam int FPL_OV_DIS_BIT     = 0;
  localparam int FPL_ST_UV          = 0;
  localparam int FPL_ST_OV          = 1;
  localparam int FPL_ST_TOTAL       = 2;
  localparam int FPL_ST_LINE        = 3;
  localparam int FPL_ST_STAGE       = 4;
  localparam int FPL_ST_DIE         = 5;

  // droop coefficient codes: 00 100%, 01 50%, 10 25%, 11 0%
  localparam logic [1:0] FPL_DROOP_100 = 2'h0;
  localparam logic [1:0] FPL_DROOP_0   = 2'h3;

  // timing
  localparam int FPL_CLK_MHZ         = 100;
  localparam int FPL_BYPASS_TIME_US  = 2000;
  localparam int FPL_BYPASS_CYCLES   = FPL_BYPASS_TIME_US * FPL_CLK_MHZ;
  localparam int FPL_HICCUP_TIME_US  = 1000;
  localparam int FPL_HICCUP_CYCLES   = FPL_HICCUP_TIME_US * FPL_CLK_MHZ;

  typedef enum logic [1:0]
  {
    FPL_LOCKOUT = 2'b00,
    FPL_RUN     = 2'b01,
    FPL_HICCUP  = 2'b11,
    FPL_LATCH   = 2'b10
  } fpl_state_e;

  typedef enum logic [1:0]
  {
    FPL_PWM_LOW    = 2'b00,
    FPL_PWM_ACTIVE = 2'b01,
    FPL_PWM_MID    = 2'b10
  } fpl_pwm_e;

endpackage

// *** hw/fpl_timer.sv ***
// one-shot down counter giving a busy window and a done pulse
`timescale 1ns/1ps
module fpl_timer
#(
  parameter int CYCLES = 200000,
  parameter int W      = $clog2(CYCLES + 1)
)
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // control
  input  wire logic start_i,
  // status
  output logic      busy_o,
  output logic      done_o
);

  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);
  localparam logic [W-1:0] ZERO = '0;

  logic [W-1:0] count;

  generate
    if (CYCLES < 1)
    begin : g_bad
      $error("timer needs at least one cycle");
    end
  endgenerate

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count  <= ZERO;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (start_i && !busy_o)
    begin
      count  <= LOAD;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end
    else if (busy_o && count == ZERO)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b1;
    end
    else
    begin
      count  <= busy_o ? count - W'(1) : count;
      done_o <= 1'b0;
    end
  end

endmodule

// *** testbench/fpl_plant_model.sv ***
// monitor and comparator levels of the power stages and supervised nodes
`timescale 1ns/1ps
module fpl_plant_model
(
  // commands from the bench
  input  wire logic [10:0] cmd_i,
  input  wire logic [7:0]  phase_current_limit_level_i,
  // monitor levels
  output logic             supply_ok_o,
  output logic             uv_cmp_o,
  output logic             ov_cmp_o,
  output logic             ov_clamp_cmp_o,
  output logic             total_current_low_o,
  output logic             line_uv_o,
  output logic             line_ok_o,
  output logic             stage_temp_high_o,
  output logic             die_hot_o,
  output logic             current_limiting_o,
  output logic             bypass_floor_hit_o,
  output logic [7:0]       phase_current_limit_adc_o
);
  // an overvoltage also trips the clamp comparator, so the two stay consistent
  assign supply_ok_o         = cmd_i[10];
  assign uv_cmp_o            = cmd_i[0];
  assign ov_cmp_o            = cmd_i[1];
  assign ov_clamp_cmp_o      = cmd_i[1] | cmd_i[2];
  assign total_current_low_o = cmd_i[3];
  assign line_uv_o           = cmd_i[4];
  assign line_ok_o           = ~(cmd_i[4] | cmd_i[5]);
  assign stage_temp_high_o   = cmd_i[6];
  assign die_hot_o           = cmd_i[7];
  assign current_limiting_o  = cmd_i[8];
  assign bypass_floor_hit_o  = cmd_i[9];
  // the limit voltage only exists while the supply is up
  assign phase_current_limit_adc_o          = cmd_i[10] ? phase_current_limit_level_i : ~phase_current_limit_level_i;
endmodule

// *** testbench/fpl_top_tb_top.sv ***
// self-checking bench of the fault protection latch
`timescale 1ns/1ps
module fpl_top_tb_top;
  import fpl_pkg::*;
  localparam int BYP = 20;
  localparam int HIC = 30;
  logic clock_i, reset_n_i, reg_write, reg_read, enable;
  logic [7:0] reg_addr, reg_wdata, phase_current_limit_level, reg_rdata_o, active_limit_o, phase_current_limit_adc;
  logic [10:0] cmd;
  logic sup, uv, ov, ovc, tot, luv, lok, stg, die, lim, flr;
  logic regulation_enable_o, soft_start_enable_o, power_good_out_o, driver_enable_out_o;
  logic limiter_active_o, limit_internal_o, die_fault_o;
  logic [1:0] droop_sel_o;
  logic [4:0] bypass_floor_o;
  fpl_pwm_e pwm_mode_o;
  int fails, n_compared;

  fpl_plant_model fpl_plant_model_inst (.cmd_i(cmd), .phase_current_limit_level_i(phase_current_limit_level),
    .supply_ok_o(sup), .uv_cmp_o(uv), .ov_cmp_o(ov), .ov_clamp_cmp_o(ovc),
    .total_current_low_o(tot), .line_uv_o(luv), .line_ok_o(lok), .stage_temp_high_o(stg),
    .die_hot_o(die), .current_limiting_o(lim), .bypass_floor_hit_o(flr),
    .phase_current_limit_adc_o(phase_current_limit_adc));

  fpl_top #(.BYPASS_CYCLES(BYP), .HICCUP_CYCLES(HIC)) fpl_top_inst (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata_o),
    .supply_ok_i(sup), .enable_i(enable), .uv_cmp_i(uv), .ov_cmp_i(ov),
    .ov_clamp_cmp_i(ovc), .total_current_low_i(tot), .line_uv_i(luv), .line_ok_i(lok),
    .stage_temp_high_i(stg), .die_hot_i(die), .current_limiting_i(lim),
    .bypass_floor_hit_i(flr), .phase_current_limit_adc_i(phase_current_limit_adc),
    .regulation_enable_o(regulation_enable_o), .soft_start_enable_o(soft_start_enable_o),
    .power_good_out_o(power_good_out_o), .driver_enable_out_o(driver_enable_out_o),
    .pwm_mode_o(pwm_mode_o), .limiter_active_o(limiter_active_o), .droop_sel_o(droop_sel_o),
    .active_limit_o(active_limit_o), .limit_internal_o(limit_internal_o),
    .bypass_floor_o(bypass_floor_o), .die_fault_o(die_fault_o));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_i);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_i);
    reg_read <= 1'b0;
    @(posedge clock_i);
    #1;
    v = reg_rdata_o;
  endtask

  task automatic wait_run();
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(posedge clock_i);
      #1;
      if (power_good_out_o === 1'b1)
        break;
    end
    if (i == 60)
    begin
      check(8'h00, 8'h01);
      end_of_test();
    end
  endtask

  // host drops and raises enable to release a latch
  task automatic toggle();
    @(posedge clock_i);
    enable <= 1'b0;
    repeat (3) @(posedge clock_i);
    enable <= 1'b1;
  endtask

  task automatic set_cmd(input int b, input logic val, input int gap);
    @(posedge clock_i);
    cmd[b] <= val;
    repeat (gap) @(posedge clock_i);
    #1;
  endtask

  task automatic t_regs();
    logic [7:0] v;
    rd(FPL_OFF_FAULT_MASK, v); check(v, 8'h00);
    rd(FPL_OFF_LIMIT_INT, v); check(v, 8'h00);
    rd(FPL_OFF_DROOP, v); check(v, 8'h03);
    rd(FPL_OFF_FLOOR, v); check(v, 8'h00);
    rd(8'h60, v); check(v, 8'h00);
    check(droop_sel_o, 8'h03);
    check(limiter_active_o, 8'h01);
    $display("test registers done");
  endtask

  task automatic t_lockout();
    enable <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    check(soft_start_enable_o, 8'h00);
    check(power_good_out_o, 8'h00);
    check(regulation_enable_o, 8'h00);
    set_cmd(10, 1'b1, 0);
    wait_run();
    check(regulation_enable_o, 8'h01);
    check(soft_start_enable_o, 8'h01);
    $display("test lockout done");
  endtask

  task automatic t_limit();
    logic [7:0] v;
    rd(FPL_OFF_LIMIT_SAMP, v); check(v, 8'h5a);
    wr(FPL_OFF_LIMIT_SAMP, 8'hff);
    rd(FPL_OFF_LIMIT_SAMP, v); check(v, 8'h5a);
    check(active_limit_o, 8'h5a);
    wr(FPL_OFF_LIMIT_INT, 8'h1f);
    rd(FPL_OFF_LIMIT_INT, v); check(v, 8'h1f);
    wr(FPL_OFF_LATCH_A, 8'h01);
    check(limit_internal_o, 8'h01);
    @(posedge clock_i);
    #1;
    check(active_limit_o, 8'h1f);
    wr(FPL_OFF_LATCH_A, 8'h00);
    @(posedge clock_i);
    #1;
    check(active_limit_o, 8'h5a);
    wr(FPL_OFF_LATCH_B, 8'h01);
    rd(FPL_OFF_LATCH_B, v);
    check(v, 8'h01);
    wr(FPL_OFF_LATCH_B, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(FPL_OFF_DROOP, k[7:0]);
      check(droop_sel_o, k[7:0]);
    end
    $display("test limit and droop done");
  endtask

  task automatic t_fault(input int b, input int st, input logic [1:0] pwm);
    logic [7:0] v;
    set_cmd(b, 1'b1, 2);
    check(power_good_out_o, 8'h00);
    check(driver_enable_out_o, 8'h00);
    check(pwm_mode_o, pwm);
    if (st == FPL_ST_DIE)
      check(die_fault_o, 8'h01);
    rd(FPL_OFF_FAULT_STATUS, v); check(v[st], 8'h01);
    set_cmd(b, 1'b0, 5);
    check(power_good_out_o, 8'h00);
    toggle();
    wait_run();
    check(pwm_mode_o, FPL_PWM_ACTIVE);
    $display("test fault %0d done", st);
  endtask

  task automatic t_line();
    cmd[5] <= 1'b1;
    set_cmd(4, 1'b1, 2);
    check(power_good_out_o, 8'h00);
    set_cmd(4, 1'b0, 0);
    toggle();
    repeat (6) @(posedge clock_i);
    #1;
    check(power_good_out_o, 8'h00);
    set_cmd(5, 1'b0, 0);
    toggle();
    wait_run();
    $display("test line done");
  endtask

  task automatic t_mask_hiccup();
    logic [7:0] v;
    int mb[3] = '{3, 4, 7};
    wr(FPL_OFF_FAULT_MASK, 8'h78);
    foreach (mb[k])
    begin
      set_cmd(mb[k], 1'b1, 3);
      check(power_good_out_o, 8'h01);
      set_cmd(mb[k], 1'b0, 0);
    end
    set_cmd(6, 1'b1, 4);
    check(power_good_out_o, 8'h01);
    rd(FPL_OFF_FAULT_STATUS, v); check(v[FPL_ST_STAGE], 8'h01);
    check(v & 8'h3c, 8'h3c);
    set_cmd(6, 1'b0, 0);
    wr(FPL_OFF_FAULT_MASK, 8'h00);
    wr(FPL_OFF_STAGE_RESP, 8'h01);
    set_cmd(6, 1'b1, 2);
    check(power_good_out_o, 8'h00);
    set_cmd(6, 1'b0, 10);
    check(power_good_out_o, 8'h00);
    wait_run();
    wr(FPL_OFF_STAGE_RESP, 8'h00);
    wr(FPL_OFF_DIE_RESP, 8'h01);
    set_cmd(7, 1'b1, 2);
    check(power_good_out_o, 8'h00);
    set_cmd(7, 1'b0, 0);
    wait_run();
    wr(FPL_OFF_DIE_RESP, 8'h00);
    $display("test mask and hiccup done");
  endtask

  // limiting and floor hit held together over one sampling edge
  task automatic floor_hit();
    @(posedge clock_i);
    cmd[8] <= 1'b1;
    cmd[9] <= 1'b1;
    @(posedge clock_i);
    cmd[8] <= 1'b0;
    cmd[9] <= 1'b0;
    #1;
  endtask

  task automatic t_bypass();
    int n;
    int i;
    wr(FPL_OFF_FLOOR, 8'h05);
    floor_hit();
    check(limiter_active_o, 8'h01);
    wr(FPL_OFF_FLOOR, 8'h85);
    check(bypass_floor_o, 8'h05);
    floor_hit();
    n = 0;
    for (i = 0; i < 100; i++)
    begin
      if (limiter_active_o === 1'b0)
        n++;
      else
        break;
      @(posedge clock_i);
      #1;
    end
    if (i == 100)
    begin
      check(8'h00, 8'h01);
      end_of_test();
    end
    check(8'(n), 8'(BYP + 1));
    check(limiter_active_o, 8'h01);
    $display("test bypass done");
  endtask

  initial
  begin
    fails = 0;
    n_compared = 0;
    reset_n_i = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    enable = 1'b0;
    cmd = 11'h000;
    phase_current_limit_level = 8'h5a;
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_lockout();
    t_limit();
    t_fault(0, FPL_ST_UV, FPL_PWM_LOW);
    t_fault(1, FPL_ST_OV, FPL_PWM_LOW);
    wr(FPL_OFF_OV_CFG, 8'h01);
    t_fault(2, FPL_ST_OV, FPL_PWM_LOW);
    wr(FPL_OFF_OV_CFG, 8'h00);
    t_fault(3, FPL_ST_TOTAL, FPL_PWM_MID);
    t_fault(6, FPL_ST_STAGE, FPL_PWM_LOW);
    t_fault(7, FPL_ST_DIE, FPL_PWM_LOW);
    t_line();
    t_mask_hiccup();
    t_bypass();
    end_of_test();
  end
endmodule
